// ==== design/boot_clock_config_select.sv ====
// boot clock configuration selector: decodes the start-up configuration word into clock controls
// Overview of operation
// - The peripheral bus clock is the system clock divided by 1, 2, 4 or 8 for divisor codes 00 to 11.
// - Clock output drives the oscillator output pin only when its disable bit is 0 and primary mode is 11 or 00.
// - Primary mode 11 is off, 10 high-speed crystal, 01 standard crystal and 00 external clock input.
// - Two-speed start-up is enabled when the switchover bit is 1 and disabled when it is 0.
// - The secondary oscillator is enabled when its enable bit is 1 and disabled when it is 0.
// - Source 111 RC/N, 101 low-power RC, 100 secondary, 011 primary+PLL, 010 primary, 001 RC/N+PLL, 000 fast RC.
// - Selection code 110 routes the fast RC through a fixed divide-by-16 to form the system clock.
module boot_clock_config_select (
  // apb
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // configuration word from non-volatile storage
  input  wire logic [31:0] cfg_word,
  // oscillator controls
  output logic [2:0]       startup_clock_source_select,
  output logic [1:0]       primary_osc_mode,
  output logic             posc_enable,
  output logic             high_speed_crystal_mode,
  output logic             standard_crystal_mode,
  output logic             external_clock_input_mode,
  output logic             two_speed_startup_enable,
  output logic             secondary_osc_enable,
  output logic             pll_enable,
  output logic             fast_rc_divider_enable,
  output logic             fast_rc_div16_enable,
  output logic             cfg_invalid,
  // derived clocks as enables
  output logic             system_clock_tick,
  output logic             peripheral_bus_clock_tick,
  output logic [1:0]       periph_bus_divisor,
  output logic             oscillator_output_pin_clock_out
);

  // ***************************************************
  // capture at reset release
  // ***************************************************
  boot_clock_pkg::capture_state_type state_q;
  logic [31:0] cfg_q;
  boot_clock_pkg::clock_cfg_type cfg_f;

  // asynchronous reset loads constants; the word itself is sampled on the first edge after release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= boot_clock_pkg::st_capture;
    end else begin
      case (state_q)
        boot_clock_pkg::st_capture: state_q <= boot_clock_pkg::st_run;
        boot_clock_pkg::st_run:     state_q <= boot_clock_pkg::st_run;
        default:                    state_q <= boot_clock_pkg::st_capture;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= 32'hffff_ffff;
    end else if (state_q == boot_clock_pkg::st_capture) begin
      cfg_q <= cfg_word;
    end
  end

  always_comb begin
    cfg_f.periph_bus_divisor_default  = cfg_q[boot_clock_pkg::pb_div_lsb +: 2];
    cfg_f.clock_out_pin_disable       = cfg_q[boot_clock_pkg::clkout_dis_bit];
    cfg_f.primary_osc_mode            = boot_clock_pkg::posc_mode_type'(cfg_q[boot_clock_pkg::posc_mode_lsb +: 2]);
    cfg_f.two_speed_startup_enable    = cfg_q[boot_clock_pkg::two_speed_bit];
    cfg_f.secondary_osc_enable        = cfg_q[boot_clock_pkg::sosc_en_bit];
    cfg_f.startup_clock_source_select = boot_clock_pkg::src_sel_type'(cfg_q[boot_clock_pkg::src_sel_lsb +: 3]);
  end

  // ***************************************************
  // decoded controls, registered
  // ***************************************************
  logic running;
  assign running = (state_q == boot_clock_pkg::st_run);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      startup_clock_source_select <= 3'h0;
      primary_osc_mode            <= 2'h3;
      posc_enable                 <= 1'b0;
      high_speed_crystal_mode     <= 1'b0;
      standard_crystal_mode       <= 1'b0;
      external_clock_input_mode   <= 1'b0;
      two_speed_startup_enable    <= 1'b0;
      secondary_osc_enable        <= 1'b0;
      pll_enable                  <= 1'b0;
      fast_rc_divider_enable      <= 1'b0;
      fast_rc_div16_enable        <= 1'b0;
      cfg_invalid                 <= 1'b0;
    end else begin
      startup_clock_source_select <= cfg_f.startup_clock_source_select;
      primary_osc_mode            <= cfg_f.primary_osc_mode;
      posc_enable <= cfg_f.primary_osc_mode != boot_clock_pkg::posc_disabled;
      high_speed_crystal_mode <= cfg_f.primary_osc_mode == boot_clock_pkg::posc_high_speed_crystal_mode;
      standard_crystal_mode <= cfg_f.primary_osc_mode == boot_clock_pkg::posc_standard_crystal_mode;
      external_clock_input_mode <= cfg_f.primary_osc_mode == boot_clock_pkg::posc_external_clock_input_mode;
      two_speed_startup_enable <= cfg_f.two_speed_startup_enable;
      secondary_osc_enable     <= cfg_f.secondary_osc_enable;
      pll_enable <= cfg_f.startup_clock_source_select == boot_clock_pkg::src_primary_pll
                 || cfg_f.startup_clock_source_select == boot_clock_pkg::src_fast_rc_divided_pll;
      fast_rc_divider_enable <= cfg_f.startup_clock_source_select == boot_clock_pkg::src_fast_rc_divided
                             || cfg_f.startup_clock_source_select == boot_clock_pkg::src_fast_rc_divided_pll;
      fast_rc_div16_enable <= cfg_f.startup_clock_source_select == boot_clock_pkg::src_fast_rc_fixed_div16;
      // flags a word that breaks the programming constraints; the device does not repair it
      cfg_invalid <= ((cfg_q & boot_clock_pkg::reserved_ones_mask) != boot_clock_pkg::reserved_ones_mask)
                  || (cfg_f.startup_clock_source_select == boot_clock_pkg::src_primary
                      && cfg_f.primary_osc_mode == boot_clock_pkg::posc_disabled);
    end
  end

  // ***************************************************
  // system clock enable: divide by 16 for code 110
  // ***************************************************
  logic [3:0] div16_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div16_q <= 4'h0;
    end else if (fast_rc_div16_enable) begin
      div16_q <= div16_q + 4'h1;
    end else begin
      div16_q <= 4'h0;
    end
  end

  logic sys_tick;
  // pclk stands in for the fast rc here; other sources tick every cycle
  assign sys_tick = running && (!fast_rc_div16_enable || div16_q == boot_clock_pkg::div16_count);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_clock_tick <= 1'b0;
    end else begin
      system_clock_tick <= sys_tick;
    end
  end

  // ***************************************************
  // peripheral bus divider, steered by software
  // ***************************************************
  logic [1:0] pb_div_q;
  logic [2:0] pb_cnt_q;
  logic [2:0] pb_last;

  always_comb begin
    case (pb_div_q)
      2'h0:    pb_last = 3'h0;
      2'h1:    pb_last = 3'h1;
      2'h2:    pb_last = 3'h3;
      2'h3:    pb_last = 3'h7;
      default: pb_last = 3'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_cnt_q                  <= 3'h0;
      peripheral_bus_clock_tick <= 1'b0;
    end else if (sys_tick) begin
      pb_cnt_q                  <= (pb_cnt_q >= pb_last) ? 3'h0 : pb_cnt_q + 3'h1;
      peripheral_bus_clock_tick <= (pb_cnt_q >= pb_last);
    end else begin
      peripheral_bus_clock_tick <= 1'b0;
    end
  end

  assign periph_bus_divisor = pb_div_q;

  // ***************************************************
  // clock output pin
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oscillator_output_pin_clock_out <= 1'b0;
    end else begin
      oscillator_output_pin_clock_out <= !cfg_f.clock_out_pin_disable && running
        && (cfg_f.primary_osc_mode == boot_clock_pkg::posc_disabled
            || cfg_f.primary_osc_mode == boot_clock_pkg::posc_external_clock_input_mode)
        && sys_tick;
    end
  end

  // ***************************************************
  // apb slave: zero wait states
  // ***************************************************
  logic wr_en;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel && penable && pwrite;

  // default divisor comes from the word at boot; software may retune it later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_div_q <= boot_clock_pkg::pb_div_reset;
    end else if (state_q == boot_clock_pkg::st_capture) begin
      pb_div_q <= cfg_word[boot_clock_pkg::pb_div_lsb +: 2];
    end else if (wr_en && paddr == boot_clock_pkg::pb_div_offset) begin
      pb_div_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        boot_clock_pkg::cfg_word_offset:   prdata <= cfg_q;
        boot_clock_pkg::clk_status_offset: prdata <= {21'h0, cfg_invalid, oscillator_output_pin_clock_out,
                                                      pll_enable, fast_rc_divider_enable, fast_rc_div16_enable,
                                                      posc_enable, two_speed_startup_enable,
                                                      secondary_osc_enable, startup_clock_source_select};
        boot_clock_pkg::pb_div_offset:     prdata <= {30'h0, pb_div_q};
        default:                           prdata <= boot_clock_pkg::unmapped_data;
      endcase
    end
  end

endmodule

// ==== inc/boot_clock_pkg.sv ====
// package: configuration word layout, codes and register map for the boot clock selector
package boot_clock_pkg;

  // ***************************************************
  // register map (byte addresses)
  // ***************************************************
  localparam logic [11:0] cfg_word_offset   = 12'h000;
  localparam logic [11:0] clk_status_offset = 12'h004;
  localparam logic [11:0] pb_div_offset     = 12'h008;
  localparam logic [31:0] unmapped_data     = 32'h0000_0000;

  // ***************************************************
  // configuration word field positions
  // ***************************************************
  localparam int pb_div_lsb        = 12;
  localparam int clkout_dis_bit    = 10;
  localparam int posc_mode_lsb     = 8;
  localparam int two_speed_bit     = 7;
  localparam int sosc_en_bit       = 5;
  localparam int src_sel_lsb       = 0;
  localparam logic [31:0] reserved_ones_mask = 32'h0000_0858;

  // ***************************************************
  // encodings
  // ***************************************************
  typedef enum logic [1:0] {
    posc_external_clock_input_mode = 2'h0,
    posc_standard_crystal_mode     = 2'h1,
    posc_high_speed_crystal_mode   = 2'h2,
    posc_disabled                  = 2'h3
  } posc_mode_type;

  typedef enum logic [2:0] {
    src_fast_internal_rc     = 3'h0,
    src_fast_rc_divided_pll  = 3'h1,
    src_primary              = 3'h2,
    src_primary_pll          = 3'h3,
    src_secondary            = 3'h4,
    src_low_power_internal_rc = 3'h5,
    src_fast_rc_fixed_div16  = 3'h6,
    src_fast_rc_divided      = 3'h7
  } src_sel_type;

  localparam logic [1:0] pb_div_reset  = 2'h0;
  localparam logic [3:0] div16_count   = 4'hf;

  typedef struct packed {
    logic [1:0]  periph_bus_divisor_default;
    logic        clock_out_pin_disable;
    posc_mode_type primary_osc_mode;
    logic        two_speed_startup_enable;
    logic        secondary_osc_enable;
    src_sel_type startup_clock_source_select;
  } clock_cfg_type;

  // one-hot state of the capture sequence
  typedef enum logic [1:0] {
    st_capture = 2'b01,
    st_run     = 2'b10
  } capture_state_type;

endpackage

// ==== dv/boot_clock_asserts.sv ====
// checker: port-level properties of the boot clock selector
module boot_clock_asserts (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // decoded controls
  input wire logic [2:0] startup_clock_source_select,
  input wire logic [1:0] primary_osc_mode,
  input wire logic       posc_enable,
  input wire logic       high_speed_crystal_mode,
  input wire logic       pll_enable,
  input wire logic       fast_rc_divider_enable,
  input wire logic       fast_rc_div16_enable,
  input wire logic       two_speed_startup_enable,
  input wire logic       secondary_osc_enable,
  // clock enables
  input wire logic       system_clock_tick,
  input wire logic       peripheral_bus_clock_tick,
  input wire logic [1:0] periph_bus_divisor,
  input wire logic       oscillator_output_pin_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ***********************
  // settle counter
  // ***********************
  // decodes land two edges after release, so checks wait for saturation
  logic [1:0] run_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 2'h0;
    end else if (run_q != 2'h3) begin
      run_q <= run_q + 2'h1;
    end
  end
  a_div16_decode: assert property (run_q == 2'h3
    |-> fast_rc_div16_enable == (startup_clock_source_select == 3'h6))
    else $error("div16 enable disagrees with source");
  a_pll_decode: assert property (run_q == 2'h3
    |-> pll_enable == (startup_clock_source_select inside {3'h1, 3'h3}))
    else $error("pll enable disagrees with source");
  a_rc_div_decode: assert property (run_q == 2'h3
    |-> fast_rc_divider_enable == (startup_clock_source_select inside {3'h1, 3'h7}))
    else $error("rc divider enable disagrees with source");
  a_posc_decode: assert property (run_q == 2'h3
    |-> posc_enable == (primary_osc_mode != 2'h3) && high_speed_crystal_mode == (primary_osc_mode == 2'h2))
    else $error("primary mode decode wrong");
  a_tick_div16: assert property (fast_rc_div16_enable && system_clock_tick |=> !system_clock_tick [*8])
    else $error("system tick too soon under divide by 16");
  a_pb_half: assert property (run_q == 2'h3 && periph_bus_divisor == 2'h1
    && $stable(periph_bus_divisor) && peripheral_bus_clock_tick |=> !peripheral_bus_clock_tick)
    else $error("bus tick twice in a row at divide by 2");
  a_clkout_gate: assert property (oscillator_output_pin_clock_out
    |-> primary_osc_mode == 2'h0 || primary_osc_mode == 2'h3)
    else $error("clock out with crystal mode");
  a_cfg_held: assert property (run_q == 2'h3
    |-> $stable({startup_clock_source_select, primary_osc_mode, two_speed_startup_enable, secondary_osc_enable}))
    else $error("captured settings changed");
endmodule

bind boot_clock_config_select boot_clock_asserts boot_clock_asserts_inst (
  .pclk                            (pclk),
  .presetn                         (presetn),
  .startup_clock_source_select     (startup_clock_source_select),
  .primary_osc_mode                (primary_osc_mode),
  .posc_enable                     (posc_enable),
  .high_speed_crystal_mode         (high_speed_crystal_mode),
  .pll_enable                      (pll_enable),
  .fast_rc_divider_enable          (fast_rc_divider_enable),
  .fast_rc_div16_enable            (fast_rc_div16_enable),
  .two_speed_startup_enable        (two_speed_startup_enable),
  .secondary_osc_enable            (secondary_osc_enable),
  .system_clock_tick               (system_clock_tick),
  .peripheral_bus_clock_tick       (peripheral_bus_clock_tick),
  .periph_bus_divisor              (periph_bus_divisor),
  .oscillator_output_pin_clock_out (oscillator_output_pin_clock_out)
);

// ==== dv/cfg_store.sv ====
// partner: non-volatile store presenting the configuration word
module cfg_store (
  // word as programmed, and a request to pass it unchecked
  input  wire logic [31:0] word_in,
  input  wire logic        break_rules,
  // word seen by the selector
  output logic [31:0]      cfg_word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] fixed_word;
  always_comb begin
    fixed_word = word_in | boot_clock_pkg::reserved_ones_mask;
    // a disabled primary paired with source 010 is stored as high-speed crystal
    if (fixed_word[2:0] == 3'h2 && fixed_word[9:8] == 2'h3) begin
      fixed_word[8] = 1'b0;
    end
  end
  assign cfg_word = break_rules ? word_in : fixed_word;
endmodule

// ==== dv/testbench.sv ====
// testbench: reset-time decode, register access and clock enable rates
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, brk, ck_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, cfg_word, word_in, cw, rd;
  logic [2:0]  startup_clock_source_select, s, xd;
  logic [1:0]  primary_osc_mode, periph_bus_divisor, m;
  logic        posc_enable, high_speed_crystal_mode, standard_crystal_mode, external_clock_input_mode;
  logic        two_speed_startup_enable, secondary_osc_enable, pll_enable, fast_rc_divider_enable;
  logic        fast_rc_div16_enable, cfg_invalid, system_clock_tick, peripheral_bus_clock_tick;
  logic        oscillator_output_pin_clock_out;
  int          fails, checks, n_sys, n_pb, n_co;
  wire logic [3:0] posc_dec = {posc_enable, high_speed_crystal_mode, standard_crystal_mode, external_clock_input_mode};
  wire logic [2:0] src_dec  = {pll_enable, fast_rc_divider_enable, fast_rc_div16_enable};
  boot_clock_config_select boot_clock_config_select_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .cfg_word(cfg_word),
    .startup_clock_source_select(startup_clock_source_select), .primary_osc_mode(primary_osc_mode),
    .posc_enable(posc_enable), .high_speed_crystal_mode(high_speed_crystal_mode),
    .standard_crystal_mode(standard_crystal_mode), .external_clock_input_mode(external_clock_input_mode),
    .two_speed_startup_enable(two_speed_startup_enable), .secondary_osc_enable(secondary_osc_enable),
    .pll_enable(pll_enable), .fast_rc_divider_enable(fast_rc_divider_enable),
    .fast_rc_div16_enable(fast_rc_div16_enable), .cfg_invalid(cfg_invalid),
    .system_clock_tick(system_clock_tick), .peripheral_bus_clock_tick(peripheral_bus_clock_tick),
    .periph_bus_divisor(periph_bus_divisor),
    .oscillator_output_pin_clock_out(oscillator_output_pin_clock_out)
  );
  cfg_store cfg_store_inst (.word_in(word_in), .break_rules(brk), .cfg_word(cfg_word));
  // ***********************
  // shared tasks
  // ***********************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      report_and_stop();
    end
    rd = prdata;
    check("slave error", {31'h0, pslverr}, 32'h0000_0000);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // counts over a whole number of periods, so tick phase does not matter
  task automatic rates(input int exp_sys, input int d);
    repeat (32) @(posedge pclk);
    n_sys = 0;
    n_pb = 0;
    n_co = 0;
    repeat (128) begin
      @(negedge pclk);
      n_sys += system_clock_tick;
      n_pb += peripheral_bus_clock_tick;
      n_co += oscillator_output_pin_clock_out;
    end
    @(posedge pclk);
    check("system ticks", n_sys, exp_sys);
    check("bus ticks", n_pb, exp_sys >> d);
    check("clock out ticks", n_co, ck_en ? exp_sys : 0);
  endtask
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ***********************
  // main sequence
  // ***********************
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    fails = 0;
    checks = 0;
    for (int i = 0; i < 9; i++) begin
      brk <= (i == 8);
      word_in <= (i == 8) ? 32'h0000_0302 : {18'h0, i[1:0], 1'b0, i[2], i[1:0], i[0], 1'b0, i[1], 2'b00, i[2:0]};
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      cw = brk ? word_in : (word_in | boot_clock_pkg::reserved_ones_mask);
      s = cw[2:0];
      m = cw[9:8];
      xd = {s == 3'h3 || s == 3'h1, s == 3'h7 || s == 3'h1, s == 3'h6};
      ck_en = !cw[10] && (m == 2'h0 || m == 2'h3);
      check("source", startup_clock_source_select, s);
      check("mode", primary_osc_mode, m);
      check("posc decode", posc_dec, {m != 2'h3, m == 2'h2, m == 2'h1, m == 2'h0});
      check("two speed", two_speed_startup_enable, cw[7]);
      check("secondary", secondary_osc_enable, cw[5]);
      check("source decode", src_dec, xd);
      check("invalid", cfg_invalid, brk);
      check("divisor", periph_bus_divisor, cw[13:12]);
      apb(1'b0, boot_clock_pkg::clk_status_offset, 32'h0000_0000);
      check("status", rd, {21'h0, brk, ck_en, xd, m != 2'h3, cw[7], cw[5], s});
      for (int d = 0; d < 4; d++) begin
        apb(1'b1, boot_clock_pkg::pb_div_offset, 32'(d));
        apb(1'b0, boot_clock_pkg::pb_div_offset, 32'h0000_0000);
        check("divisor read", rd, 32'(d));
        rates(s == 3'h6 ? 8 : 128, d);
      end
      apb(1'b1, boot_clock_pkg::cfg_word_offset, 32'h0000_0000);
      apb(1'b0, boot_clock_pkg::cfg_word_offset, 32'h0000_0000);
      check("word", rd, cw);
      apb(1'b0, 12'h00c, 32'h0000_0000);
      check("unmapped", rd, 32'h0000_0000);
      word_in <= ~word_in;
      repeat (4) @(posedge pclk);
      check("held source", startup_clock_source_select, s);
      $display("test %0d done", i);
    end
    report_and_stop();
  end
endmodule
